/* hdl/hpm_pkg.sv */
package hpm_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int SYNC_W = 5;
  localparam int PEND_W = 8;
  localparam int SETTLE_W = 3;

  // ---------------------------------------------------------------
  // synchroniser lane positions
  // ---------------------------------------------------------------
  localparam int LANE_MODE_N = 0;
  localparam int LANE_LIN_STRAP = 1;
  localparam int LANE_PIN_A = 2;
  localparam int LANE_PIN_B = 3;
  localparam int LANE_ALERT = 4;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h1_F;
  localparam logic [PEND_W-1:0] PEND_ZERO = 8'h0_0;
  localparam logic [PEND_W-1:0] PEND_ONE = 8'h0_1;
  localparam logic [PEND_W-1:0] PEND_MAX = 8'hF_F;
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 3'h0;
  localparam logic [SETTLE_W-1:0] SETTLE_ONE = 3'h1;
  // three flops plus one agreement cycle before the strap is trusted
  localparam logic [SETTLE_W-1:0] SETTLE_CYC = 3'h4;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HPM_MODE_NONE,
    HPM_MODE_I2C,
    HPM_MODE_SPI,
    HPM_MODE_LIN
  } hpm_mode_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] clean;
  } hpm_sync_state_t;

  typedef struct packed {
    hpm_mode_t mode;
    logic [SETTLE_W-1:0] settle;
    logic [PEND_W-1:0] pend;
    logic pend_overflow;
    logic pin_a_out;
    logic pin_a_oe_n;
    logic pin_b_out;
    logic pin_b_oe_n;
    logic alert_out;
    logic alert_oe_n;
    logic i2c_sda_in;
    logic i2c_scl_in;
    logic spi_sck;
    logic spi_selected;
    logic lin_rx;
    logic alert_line_low;
  } hpm_state_t;
endpackage

/* hdl/hpm_sync_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface hpm_sync_if;
  import hpm_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] clean;
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface // hpm_sync_if
`default_nettype wire

/* hdl/hpm_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module hpm_pin_sync (
  input wire logic clk,
  input wire logic nrst,
  hpm_sync_if.sync_side bus
);
  import hpm_pkg::*;

  hpm_sync_state_t st_ff;
  hpm_sync_state_t nxt_st;

  // ---------------------------------------------------------------
  // three flops; a lane changes once stages two and three agree
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = bus.raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < SYNC_W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.clean[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, clean: SYNC_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.clean = st_ff.clean;
endmodule // hpm_pin_sync
`default_nettype wire

/* hdl/hpm_host_port.sv */
// How it works
// [RULE1] alert pin is pulled low while any report waits for the host; code does so in i2c and spi modes only
// [RULE2] alert pin is released when nothing is pending; in lin mode the code follows lin_xcvr_enable instead
// [RULE3] each consumed report leaves the count; release only at zero
// [RULE4] host must sense the alert by level, never by edge
// [RULE5] in lin mode the alert pin carries the transceiver enable
// [RULE6] slave-mode strap chooses the role of both shared pins
// [RULE7] i2c mode: pin a is open-drain bidirectional data
// [RULE8] spi mode: pin a is the serial clock input from host
// [RULE9] lin mode: pin a is receive input from transceiver
// [RULE10] i2c mode: pin b is the clock line from host
// [RULE11] spi mode: pin b is active-low select; respond only while low
// [RULE12] lin mode: pin b is driven as transmit output
// [RULE13] alert pin is only driven low or released, never high
`timescale 1ns/100ps
`default_nettype none
module hpm_host_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slave_mode_select_n,
  input wire logic lin_mode_strap,
  input wire logic host_shared_pin_a_in,
  output logic host_shared_pin_a_out,
  output logic host_shared_pin_a_oe_n,
  input wire logic host_shared_pin_b_in,
  output logic host_shared_pin_b_out,
  output logic host_shared_pin_b_oe_n,
  input wire logic host_report_alert_n_in,
  output logic host_report_alert_n_out,
  output logic host_report_alert_n_oe_n,
  input wire logic report_post,
  input wire logic report_consumed,
  input wire logic i2c_sda_drive_low,
  input wire logic lin_tx,
  input wire logic lin_xcvr_enable,
  output hpm_pkg::hpm_mode_t port_mode,
  output logic [hpm_pkg::PEND_W-1:0] pending_count,
  output logic pending_overflow,
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  output logic spi_sck,
  output logic spi_selected,
  output logic lin_rx,
  output logic alert_line_low
);
  import hpm_pkg::*;

  hpm_state_t st_ff;
  hpm_state_t nxt_st;
  // one bundle carries every pin through the synchroniser
  hpm_sync_if sync_bus ();
  logic [SYNC_W-1:0] pins;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign sync_bus.raw = {
    host_report_alert_n_in,
    host_shared_pin_b_in,
    host_shared_pin_a_in,
    lin_mode_strap,
    slave_mode_select_n
  };
  assign pins = sync_bus.clean;

  hpm_pin_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .bus(sync_bus.sync_side)
  );

  // ---------------------------------------------------------------
  // synchronised pin levels
  // ---------------------------------------------------------------
  logic strap_sel_n;
  logic strap_lin;
  logic pin_a_lvl;
  logic pin_b_lvl;
  logic alert_lvl;

  assign strap_sel_n = pins[LANE_MODE_N];
  assign strap_lin = pins[LANE_LIN_STRAP];
  assign pin_a_lvl = pins[LANE_PIN_A];
  assign pin_b_lvl = pins[LANE_PIN_B];
  assign alert_lvl = pins[LANE_ALERT];

  // select low wins; the lin strap only splits spi from lin
  function automatic hpm_mode_t decode_mode(input logic sel_n,
                                            input logic lin_strap);
    if (!sel_n) begin
      return HPM_MODE_I2C;
    end else if (lin_strap) begin
      return HPM_MODE_LIN;
    end else begin
      return HPM_MODE_SPI;
    end
  endfunction

  // released while nothing waits for the host
  function automatic logic none_pending(input logic [PEND_W-1:0] pend);
    return pend == PEND_ZERO;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // strap caught once, after synchronisers settle
    // frozen so a strap glitch cannot swap pin roles mid-transfer
    if (st_ff.mode == HPM_MODE_NONE) begin
      if (st_ff.settle == SETTLE_CYC) begin
        nxt_st.mode = decode_mode(strap_sel_n, strap_lin); // [RULE6]
      end else begin
        nxt_st.settle = st_ff.settle + SETTLE_ONE;
      end
    end

    // pending reports; a post and a consume together cancel
    // saturates; a post lost at full count is flagged, never wrapped
    if (report_post && !report_consumed) begin
      if (st_ff.pend == PEND_MAX) begin
        nxt_st.pend_overflow = 1'b1;
      end else begin
        nxt_st.pend = st_ff.pend + PEND_ONE;
      end
    end else if (report_consumed && !report_post) begin
      // a consume with nothing pending is refused
      if (st_ff.pend != PEND_ZERO) begin
        nxt_st.pend = st_ff.pend - PEND_ONE; // [RULE3]
      end
    end

    // defaults: everything released until mode is known
    nxt_st.pin_a_out = 1'b0;
    nxt_st.pin_a_oe_n = 1'b1;
    nxt_st.pin_b_out = 1'b0;
    nxt_st.pin_b_oe_n = 1'b1;
    nxt_st.alert_out = 1'b0; // [RULE13]
    nxt_st.alert_oe_n = 1'b1;
    nxt_st.i2c_sda_in = 1'b1;
    nxt_st.i2c_scl_in = 1'b1;
    nxt_st.spi_sck = 1'b0;
    nxt_st.spi_selected = 1'b0;
    nxt_st.lin_rx = 1'b1;
    // readback of the wired alert level
    nxt_st.alert_line_low = !alert_lvl;

    // pin roles follow the latched mode
    case (st_ff.mode)
      HPM_MODE_I2C: begin
        // sda is open drain: only low is ever driven
        nxt_st.pin_a_oe_n = !i2c_sda_drive_low; // [RULE7]
        nxt_st.i2c_sda_in = pin_a_lvl; // [RULE7]
        nxt_st.i2c_scl_in = pin_b_lvl; // [RULE10]
        nxt_st.alert_oe_n = none_pending(nxt_st.pend); // [RULE1] [RULE2]
      end
      HPM_MODE_SPI: begin
        nxt_st.spi_sck = pin_a_lvl; // [RULE8]
        nxt_st.spi_selected = !pin_b_lvl; // [RULE11]
        nxt_st.alert_oe_n = none_pending(nxt_st.pend); // [RULE1] [RULE2]
      end
      HPM_MODE_LIN: begin
        // tx is push-pull; the alert pin stays open drain
        nxt_st.lin_rx = pin_a_lvl; // [RULE9]
        nxt_st.pin_b_out = lin_tx; // [RULE12]
        nxt_st.pin_b_oe_n = 1'b0; // [RULE12]
        // enable high lets the pull-up raise the line
        nxt_st.alert_oe_n = lin_xcvr_enable; // [RULE5] [RULE13]
      end
      default: begin
        nxt_st.alert_oe_n = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // every pin field resets to its released level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '{
        mode: HPM_MODE_NONE,
        settle: SETTLE_ZERO,
        pend: PEND_ZERO,
        pend_overflow: 1'b0,
        pin_a_out: 1'b0,
        pin_a_oe_n: 1'b1,
        pin_b_out: 1'b0,
        pin_b_oe_n: 1'b1,
        alert_out: 1'b0,
        alert_oe_n: 1'b1,
        i2c_sda_in: 1'b1,
        i2c_scl_in: 1'b1,
        spi_sck: 1'b0,
        spi_selected: 1'b0,
        lin_rx: 1'b1,
        alert_line_low: 1'b0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign host_shared_pin_a_out = st_ff.pin_a_out;
  assign host_shared_pin_a_oe_n = st_ff.pin_a_oe_n;
  assign host_shared_pin_b_out = st_ff.pin_b_out;
  assign host_shared_pin_b_oe_n = st_ff.pin_b_oe_n;
  assign host_report_alert_n_out = st_ff.alert_out;
  assign host_report_alert_n_oe_n = st_ff.alert_oe_n;
  assign port_mode = st_ff.mode;
  assign pending_count = st_ff.pend;
  assign pending_overflow = st_ff.pend_overflow;
  assign i2c_sda_in = st_ff.i2c_sda_in;
  assign i2c_scl_in = st_ff.i2c_scl_in;
  assign spi_sck = st_ff.spi_sck;
  assign spi_selected = st_ff.spi_selected;
  assign lin_rx = st_ff.lin_rx;
  assign alert_line_low = st_ff.alert_line_low;
endmodule // hpm_host_port
`default_nettype wire

/* test/hpm_host_port_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module hpm_host_port_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire hpm_pkg::hpm_mode_t port_mode,
  input wire logic [hpm_pkg::PEND_W-1:0] pending_count,
  input wire logic report_post,
  input wire logic report_consumed,
  input wire logic i2c_sda_drive_low,
  input wire logic lin_tx,
  input wire logic lin_xcvr_enable,
  input wire logic host_shared_pin_a_oe_n,
  input wire logic host_shared_pin_b_out,
  input wire logic host_shared_pin_b_oe_n,
  input wire logic host_report_alert_n_out,
  input wire logic host_report_alert_n_oe_n
);
  import hpm_pkg::*;
  // ----------------
  // port checks
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire hs = port_mode == HPM_MODE_I2C || port_mode == HPM_MODE_SPI;
  wire ln = port_mode == HPM_MODE_LIN;
  wire ic = port_mode == HPM_MODE_I2C;
  AST_ALERT_SET:
    assert property (hs && $stable(port_mode) && pending_count != 8'h0_0
      |-> !host_report_alert_n_oe_n) else $error("alert not low");
  AST_ALERT_FREE:
    assert property (hs && $stable(port_mode) && pending_count == 8'h0_0
      |-> host_report_alert_n_oe_n) else $error("alert not free");
  AST_CNT_DOWN:
    assert property (report_consumed && !report_post
      && pending_count != 8'h0_0
      |=> pending_count == $past(pending_count) - 8'h0_1)
      else $error("consume lost");
  AST_LIN_EN:
    assert property (ln && $past(ln)
      |-> host_report_alert_n_oe_n == $past(lin_xcvr_enable))
      else $error("enable wrong");
  AST_LIN_TX:
    assert property (ln && $past(ln) |-> !host_shared_pin_b_oe_n
      && host_shared_pin_b_out == $past(lin_tx)) else $error("tx wrong");
  AST_SDA:
    assert property (ic && $past(ic)
      |-> host_shared_pin_a_oe_n == !$past(i2c_sda_drive_low))
      else $error("sda wrong");
  AST_B_IN:
    assert property (hs |-> host_shared_pin_b_oe_n) else $error("b driven");
  AST_MODE_HOLD:
    assert property (port_mode != HPM_MODE_NONE |=> $stable(port_mode))
      else $error("mode moved");
  AST_OD:
    assert property (!host_report_alert_n_out) else $error("alert high");
endmodule // hpm_host_port_monitor
bind hpm_host_port hpm_host_port_monitor mon_u (.clk(clk), .nrst(nrst),
  .port_mode(port_mode), .pending_count(pending_count),
  .report_post(report_post), .report_consumed(report_consumed),
  .i2c_sda_drive_low(i2c_sda_drive_low), .lin_tx(lin_tx),
  .lin_xcvr_enable(lin_xcvr_enable),
  .host_shared_pin_a_oe_n(host_shared_pin_a_oe_n),
  .host_shared_pin_b_out(host_shared_pin_b_out),
  .host_shared_pin_b_oe_n(host_shared_pin_b_oe_n),
  .host_report_alert_n_out(host_report_alert_n_out),
  .host_report_alert_n_oe_n(host_report_alert_n_oe_n));
`default_nettype wire

/* test/hpm_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hpm_host_model (
  input wire logic a_oe_n,
  input wire logic a_out,
  input wire logic b_oe_n,
  input wire logic b_out,
  input wire logic alert_oe_n,
  input wire logic alert_out,
  input wire logic host_a_en,
  input wire logic host_a,
  input wire logic host_b_en,
  input wire logic host_b,
  output logic pin_a,
  output logic pin_b,
  output logic alert_line
);
  // ----------------
  // wired pins, pull-ups
  // ----------------
  assign pin_a = (a_oe_n | a_out) & (!host_a_en | host_a);
  assign pin_b = (b_oe_n | b_out) & (!host_b_en | host_b);
  // host senses this level
  assign alert_line = alert_oe_n | alert_out;
endmodule // hpm_host_model
`default_nettype wire

/* test/hpm_host_port_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module hpm_host_port_tb_top;
  import hpm_pkg::*;
  logic clk, nrst, sel_n, lin_st, post, cons, sda_lo, lin_tx, lin_en;
  logic ha_en, ha, hb_en, hb, pa, pb, al, a_out, a_oe_n, b_out, b_oe_n;
  logic al_out, al_oe_n, scl, sck, sel, rx, ovf, sda, al_low;
  hpm_mode_t mode;
  logic [7:0] cnt, last_cnt;
  logic [7:0] exp_q[$];
  int errors, num_checks, nr;
  int seed = 32'h7d2a;
  hpm_mode_t mtab [3] = '{HPM_MODE_I2C, HPM_MODE_SPI, HPM_MODE_LIN};
  hpm_host_port dut_u (.clk(clk), .nrst(nrst), .slave_mode_select_n(sel_n),
    .lin_mode_strap(lin_st), .host_shared_pin_a_in(pa),
    .host_shared_pin_a_out(a_out), .host_shared_pin_a_oe_n(a_oe_n),
    .host_shared_pin_b_in(pb), .host_shared_pin_b_out(b_out),
    .host_shared_pin_b_oe_n(b_oe_n), .host_report_alert_n_in(al),
    .host_report_alert_n_out(al_out), .host_report_alert_n_oe_n(al_oe_n),
    .report_post(post), .report_consumed(cons), .i2c_sda_drive_low(sda_lo),
    .lin_tx(lin_tx), .lin_xcvr_enable(lin_en), .port_mode(mode),
    .pending_count(cnt), .pending_overflow(ovf), .i2c_sda_in(sda),
    .i2c_scl_in(scl), .spi_sck(sck), .spi_selected(sel), .lin_rx(rx),
    .alert_line_low(al_low));
  hpm_host_model host_u (.a_oe_n(a_oe_n), .a_out(a_out), .b_oe_n(b_oe_n),
    .b_out(b_out), .alert_oe_n(al_oe_n), .alert_out(al_out),
    .host_a_en(ha_en), .host_a(ha), .host_b_en(hb_en), .host_b(hb),
    .pin_a(pa), .pin_b(pb), .alert_line(al));
  // ----------------
  // helpers
  // ----------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge clk) begin
    if (!nrst) last_cnt <= 8'h0_0;
    else if (cnt !== last_cnt) begin
      last_cnt <= cnt;
      if (exp_q.size() == 0) chk("stray_count", cnt, last_cnt);
      else chk("pending_count", cnt, exp_q.pop_front());
    end
  end
  initial begin
    #200000;
    errors++;
    close_out();
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    {nrst, sel_n, lin_st, post, cons, sda_lo, lin_tx, ha_en, ha} = '0;
    {hb_en, hb, lin_en} = '1;
    foreach (mtab[m]) begin
      nrst = 1'b0;
      sel_n = m != 0;
      lin_st = m == 2;
      ha_en = m != 0;
      hb_en = m != 2;
      {hb, lin_en, sda_lo} = 3'h6;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      for (int i = 0; i < 20 && mode === HPM_MODE_NONE; i++) @(negedge clk);
      chk("port_mode", 8'(mode), 8'(mtab[m]));
      if (mode === HPM_MODE_NONE) close_out();
      nr = (m == 1) ? 255 : 1 + ($random(seed) & 3);
      for (int i = 1; i <= nr; i++) begin
        post = 1'b1;
        exp_q.push_back(8'(i));
        @(negedge clk);
      end
      // one post beyond a full count is lost and flagged
      if (nr == 255) @(negedge clk);
      post = 1'b0;
      chk("alert_line", 8'(al), 8'(m == 2));
      chk("overflow", 8'(ovf), 8'(nr == 255));
      chk("unselected", 8'(sel), 8'h0_0);
      for (int i = nr - 1; i >= 0; i--) begin
        cons = 1'b1;
        exp_q.push_back(8'(i));
        @(negedge clk);
      end
      @(negedge clk);
      cons = 1'b0;
      chk("alert_free", 8'(al_oe_n), 8'h0_1);
      {sda_lo, hb, lin_en} = 3'h4;
      ha = 1'($random(seed));
      lin_tx = 1'($random(seed));
      repeat (7) @(negedge clk);
      case (m)
        0: begin
          chk("sda_oe_n", 8'(a_oe_n), 8'h0_0);
          chk("sda_in", 8'(sda), 8'h0_0);
          chk("scl_in", 8'(scl), 8'h0_0);
        end
        1: begin
          chk("sck", 8'(sck), 8'(ha));
          chk("selected", 8'(sel), 8'h0_1);
        end
        default: begin
          chk("rx", 8'(rx), 8'(ha));
          chk("tx", 8'(pb), 8'(lin_tx));
          chk("xcvr_en", 8'(al), 8'h0_0);
          chk("alert_out", 8'(al_out), 8'h0_0);
        end
      endcase
      chk("alert_seen", 8'(al_low), 8'(m == 2));
      chk("a_out", 8'(a_out), 8'h0_0);
    end
    close_out();
  end
endmodule // hpm_host_port_tb_top
`default_nettype wire
